// ===== hw/hspsi_top.sv
// Serial port selection, port lock, transfer record and two-wire slave
`timescale 1ns/100ps

module hspsi_top
  import hspsi_pkg::*;
#(
  parameter logic [7:0] DIE_VERSION = 8'h01  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        shared_select_pin_i,
  input  wire logic        spi_cfg_wr_i,
  output logic             spi_sel_o,
  output logic             port_lock_o,
  output logic             fast_capture_en_o,
  output logic [15:0]      ext_addr_o,
  output logic [31:0]      ext_wdata_o,
  output logic             ext_wr_o,
  input  wire logic [31:0] ext_rdata_i,
  input  wire logic [2:0]  ext_bytes_i
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_bytes(input logic [15:0] a, input logic [2:0] e);
    case (a)
      A_LAST_D32:                            reg_bytes = 3'h4;
      A_LAST_ADDR, A_LAST_D16:               reg_bytes = 3'h2;
      A_DIE_VER, A_LAST_D8, A_LOCK_CFG, A_LAST_OPERATION_KIND: reg_bytes = 3'h1;
      default:                               reg_bytes = e;
    endcase
  endfunction
  function automatic logic is_record(input logic [15:0] a);
    is_record = (a == A_LAST_D32) || (a == A_LAST_D8) || (a == A_LAST_ADDR) ||
                (a == A_LAST_D16) || (a == A_LAST_OPERATION_KIND);
  endfunction
  function automatic logic is_local(input logic [15:0] a);
    is_local = is_record(a) || (a == A_DIE_VER) || (a == A_LOCK_CFG);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_p;
  logic sda_s1, sda_s2, sda_p;
  logic sel_s1, sel_s2, sel_p;

  always_ff @(posedge clk_i) begin
    scl_s1 <= scl_i;
    scl_s2 <= scl_s1;
    scl_p  <= scl_s2;
    sda_s1 <= sda_i;
    sda_s2 <= sda_s1;
    sda_p  <= sda_s2;
    sel_s1 <= shared_select_pin_i;
    sel_s2 <= sel_s1;
    sel_p  <= sel_s2;
  end

  logic start_c, stop_c, rise_c, fall_c, sel_fall;
  // Edges are found on the system clock; a 400 kHz clock gives SCL_MIN_CYC per bit
  assign rise_c   = ~scl_p & scl_s2;
  assign fall_c   = scl_p & ~scl_s2;
  assign start_c  = scl_p & scl_s2 & sda_p & ~sda_s2;
  assign stop_c   = scl_p & scl_s2 & ~sda_p & sda_s2;
  assign sel_fall = sel_p & ~sel_s2;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  hspsi_state_type st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic        idx_q, idx_d, pv_q, pv_d, ack_q, ack_d, drv_q, drv_d;
  logic [15:0] ptr_q, ptr_d;
  logic [2:0]  bc_q, bc_d;
  logic [31:0] wd_q, wd_d, tx_q, tx_d, rdv_q, rdv_d;
  logic        spi_q, spi_d, lock_q, lock_d, fcap_q, fcap_d, wr_q, wr_d;
  logic [1:0]  tog_q, tog_d;
  logic [7:0]  cfg_q, cfg_d, op_q, op_d;
  logic [15:0] la_q, la_d;
  logic [31:0] ld_q, ld_d;

  logic [7:0]  b_in;
  logic [2:0]  nb;
  logic [31:0] rv, msk, wdn;
  logic [5:0]  nbits;

  assign b_in  = {sh_q[6:0], sda_s2};
  assign nb    = reg_bytes(ptr_q, ext_bytes_i);
  assign nbits = {nb, 3'h0};
  assign msk   = ~(32'hffffffff << nbits);
  assign wdn   = {wd_q[23:0], b_in};

  // Local read mux; everything else comes from the register map outside
  always_comb begin
    case (ptr_q)
      A_DIE_VER:   rv = {24'h000000, DIE_VERSION};
      A_LAST_D8:   rv = {24'h000000, ld_q[7:0]};
      A_LAST_D16:  rv = {16'h0000, ld_q[15:0]};
      A_LAST_D32:  rv = ld_q;
      A_LAST_ADDR: rv = {16'h0000, la_q};
      A_LOCK_CFG:  rv = {24'h000000, cfg_q};
      A_LAST_OPERATION_KIND:   rv = {24'h000000, op_q};
      default:     rv = ext_rdata_i & msk;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    idx_d  = idx_q;
    pv_d   = pv_q;
    ack_d  = ack_q;
    drv_d  = drv_q;
    ptr_d  = ptr_q;
    bc_d   = bc_q;
    wd_d   = wd_q;
    tx_d   = tx_q;
    rdv_d  = rdv_q;
    spi_d  = spi_q;
    lock_d = lock_q;
    tog_d  = tog_q;
    cfg_d  = cfg_q;
    op_d   = op_q;
    la_d   = la_q;
    ld_d   = ld_q;
    wr_d   = 1'b0;

    // Port selection by select-pin toggles until locked
    if (!lock_q && !spi_q && sel_fall) begin
      if (tog_q == SEL_TOGGLES - 2'h1) begin
        spi_d = 1'b1;
      end else begin
        tog_d = tog_q + 2'h1;
      end
    end
    if (spi_q && spi_cfg_wr_i) begin
      lock_d = 1'b1;
    end

    if (spi_q) begin
      st_d  = ST_IDLE;
      drv_d = 1'b0;
    end else if (start_c) begin
      st_d  = ST_DEV;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop_c) begin
      st_d  = ST_IDLE;
      drv_d = 1'b0;
    end else if (st_q != ST_IDLE && rise_c) begin
      if (cnt_q != ACK_SLOT) begin
        sh_d  = b_in;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == 4'h7) begin
          case (st_q)
            ST_DEV: begin
              ack_d = 1'b0;
              st_d  = ST_SKIP;
              if (b_in[7:1] == DEV_ADDR) begin
                if (!b_in[0]) begin
                  ack_d = 1'b1;
                  st_d  = ST_ADDR;
                  idx_d = 1'b0;
                end else if (pv_q) begin
                  ack_d = 1'b1;
                  st_d  = ST_RD;
                  tx_d  = rv << (6'h20 - nbits);
                  rdv_d = rv;
                  bc_d  = 3'h0;
                end
              end
            end
            ST_ADDR: begin
              ack_d = 1'b1;
              idx_d = 1'b1;
              if (!idx_q) begin
                ptr_d[15:8] = b_in;
                pv_d        = 1'b0;
              end else begin
                ptr_d[7:0] = b_in;
                pv_d       = 1'b1;
                st_d       = ST_WR;
                bc_d       = 3'h0;
                wd_d       = 32'h00000000;
              end
            end
            ST_WR: begin
              ack_d = 1'b1;
              if (bc_q < nb) begin
                wd_d = wdn;
                bc_d = bc_q + 3'h1;
                if (bc_q == nb - 3'h1) begin
                  op_d = OP_WRITE;
                  la_d = ptr_q;
                  ld_d = wdn;
                  if (ptr_q == A_LOCK_CFG) begin
                    cfg_d = wdn[7:0];
                    if (wdn[LOCK_BIT]) begin
                      lock_d = 1'b1;
                    end
                  end else if (!is_local(ptr_q)) begin
                    wr_d = 1'b1;
                  end
                end
              end
            end
            default: ack_d = 1'b0;
          endcase
        end
      end else begin
        cnt_d = 4'h0;
        if (st_q == ST_RD && !ack_q) begin  // Own acknowledge after 0x71 is no master reply
          if (bc_q == nb - 3'h1) begin
            st_d = ST_SKIP;
            if (sda_s2 && !is_record(ptr_q)) begin
              op_d = OP_READ;
              la_d = ptr_q;
              ld_d = rdv_q;
            end
          end else if (sda_s2) begin
            st_d = ST_SKIP;
          end else begin
            tx_d = {tx_q[23:0], 8'h00};
            bc_d = bc_q + 3'h1;
          end
        end
      end
    end else if (st_q != ST_IDLE && fall_c) begin
      // Drive low only: acknowledge slot or a zero data bit
      drv_d = ((cnt_q == ACK_SLOT) && ack_q) ||
              ((st_q == ST_RD) && (cnt_q < ACK_SLOT) &&
               !tx_q[{2'h3, ~cnt_q[2:0]}]);
    end

    fcap_d = cfg_d[FCAP_BIT] & ~spi_d;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    st_q   <= reset_i ? ST_IDLE      : st_d;
    cnt_q  <= reset_i ? 4'h0         : cnt_d;
    sh_q   <= reset_i ? 8'h00        : sh_d;
    idx_q  <= reset_i ? 1'b0         : idx_d;
    pv_q   <= reset_i ? 1'b0         : pv_d;
    ack_q  <= reset_i ? 1'b0         : ack_d;
    drv_q  <= reset_i ? 1'b0         : drv_d;
    ptr_q  <= reset_i ? 16'h0000     : ptr_d;
    bc_q   <= reset_i ? 3'h0         : bc_d;
    wd_q   <= reset_i ? 32'h00000000 : wd_d;
    tx_q   <= reset_i ? 32'h00000000 : tx_d;
    rdv_q  <= reset_i ? 32'h00000000 : rdv_d;
    spi_q  <= reset_i ? 1'b0         : spi_d;
    lock_q <= reset_i ? 1'b0         : lock_d;
    fcap_q <= reset_i ? 1'b0         : fcap_d;
    tog_q  <= reset_i ? 2'h0         : tog_d;
    cfg_q  <= reset_i ? CFG_RESET    : cfg_d;
    op_q   <= reset_i ? 8'h00        : op_d;
    la_q   <= reset_i ? 16'h0000     : la_d;
    ld_q   <= reset_i ? 32'h00000000 : ld_d;
    wr_q   <= reset_i ? 1'b0         : wr_d;
    sda_o  <= 1'b0;
  end

  assign sda_oe_o          = drv_q;
  assign spi_sel_o         = spi_q;
  assign port_lock_o       = lock_q;
  assign fast_capture_en_o = fcap_q;
  assign ext_addr_o        = ptr_q;
  assign ext_wdata_o       = wd_q;
  assign ext_wr_o          = wr_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_ack_fall;
    (st_q == ST_WR) && fall_c && (cnt_q == ACK_SLOT) && !start_c && !stop_c;
  endsequence

  fcap_gated_a: assert property (fast_capture_en_o |-> cfg_q[FCAP_BIT] && !spi_q)
    else $error("fast capture enabled without its bit");
  spi_sticky_a: assert property (spi_q |=> spi_q)
    else $error("four-wire selection dropped");
  lock_freeze_a: assert property (lock_q && !spi_q |=> !spi_q [*4])
    else $error("port switched after lock");
  spi_lock_a: assert property (spi_q && spi_cfg_wr_i |=> lock_q)
    else $error("config write did not lock four-wire port");
  lock_keep_a: assert property (lock_q |=> lock_q && $stable(spi_q))
    else $error("lock released");
  addr_record_a: assert property ($changed(la_q) |-> la_q == $past(ptr_q))
    else $error("recorded address not the pointer");
  op_code_a: assert property ($changed(op_q) |-> op_q == OP_WRITE || op_q == OP_READ)
    else $error("bad operation code");
  read_keep_a: assert property ($changed(op_q) && op_q == OP_READ |-> !is_record(la_q))
    else $error("record read was recorded");
  sda_low_a: assert property ($rose(sda_oe_o) |-> !scl_s2 && !sda_o)
    else $error("data line driven while clock high");
  wr_ack_a: assert property (s_ack_fall ##0 ack_q |=> sda_oe_o)
    else $error("received byte not acknowledged");
  ext_count_a: assert property (ext_wr_o |-> bc_q == nb && !is_local(ptr_q))
    else $error("write strobe at wrong byte count");
endmodule

// ===== hw/hspsi_pkg.sv
// Constants and types for the serial port select and two-wire register slave
package hspsi_pkg;
  // Two-wire slave address and register map
  localparam logic [6:0]  DEV_ADDR    = 7'h38;
  localparam logic [15:0] A_LAST_D32  = 16'he5ff;
  localparam logic [15:0] A_DIE_VER   = 16'he707;
  localparam logic [15:0] A_LAST_D8   = 16'he7fd;
  localparam logic [15:0] A_LAST_ADDR = 16'he9fe;
  localparam logic [15:0] A_LAST_D16  = 16'he9ff;
  localparam logic [15:0] A_LOCK_CFG  = 16'hea00;
  localparam logic [15:0] A_LAST_OPERATION_KIND   = 16'hea01;
  // Recorded operation kinds
  localparam logic [7:0]  OP_WRITE    = 8'hca;
  localparam logic [7:0]  OP_READ     = 8'h35;
  // Field positions in port_lock_config, and its reset value
  localparam int          LOCK_BIT    = 0;
  localparam int          FCAP_BIT    = 1;
  localparam logic [7:0]  CFG_RESET   = 8'h00;
  // Falling edges of the select pin that choose the four-wire port
  localparam logic [1:0]  SEL_TOGGLES = 2'h3;
  // Fastest serial clock and the shortest period it gives in system clocks
  localparam int          SCL_MAX_KHZ = 400;
  localparam int          CLK_KHZ     = 40000;
  localparam int          SCL_MIN_CYC = CLK_KHZ / SCL_MAX_KHZ;
  // Bit slot of the acknowledge in a nine-clock byte
  localparam logic [3:0]  ACK_SLOT    = 4'h8;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV  = 6'h02,
    ST_ADDR = 6'h04,
    ST_WR   = 6'h08,
    ST_RD   = 6'h10,
    ST_SKIP = 6'h20
  } hspsi_state_type;
endpackage

// ===== testbench/hspsi_master_model.sv
// Two-wire bus master model: drives the clock and an open-drain data line
`timescale 1ns/100ps
module hspsi_master_model #(
  parameter int QTR_NS = 625
) (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One clock period of four quarters, 2.5 us, the fastest allowed
  task automatic clock_bit(input logic b, output logic s);
    sda_o = b;
    #(QTR_NS);
    scl_o = 1'b1;
    #(QTR_NS);
    s = sda_i;
    #(QTR_NS);
    scl_o = 1'b0;
    #(QTR_NS);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start();
    sda_o = 1'b1;
    #(QTR_NS);
    scl_o = 1'b1;
    #(QTR_NS);
    sda_o = 1'b0;
    #(QTR_NS);
    scl_o = 1'b0;
    #(QTR_NS);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #(QTR_NS);
    scl_o = 1'b1;
    #(QTR_NS);
    sda_o = 1'b1;
    #(QTR_NS);
  endtask

  // Byte out MSB first, then the slave's acknowledge slot
  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(v[i], s);
    end
    clock_bit(1'b1, ack);
  endtask

  // Byte in MSB first; acknowledge all but the last byte
  task automatic recv_byte(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, v[i]);
    end
    clock_bit(last, s);
  endtask
endmodule

// ===== testbench/hspsi_top_tb.sv
// Self-checking bench for port selection, lock, transfer record and slave
`timescale 1ns/100ps
module hspsi_top_tb;
  import hspsi_pkg::*;
  typedef struct {
    logic        wr;
    logic [15:0] addr;
    int          nb;
    logic [31:0] data;
  } hspsi_row_type;

  logic        clk_i, reset_i, scl, m_sda, sda_w, sda_o, sda_oe_o;
  logic        shared_select_pin_i, spi_cfg_wr_i, spi_sel_o, port_lock_o;
  logic        fast_capture_en_o, ext_wr_o, ack;
  logic [15:0] ext_addr_o;
  logic [31:0] ext_wdata_o, ext_rdata_i, ext_q, rd;
  logic [2:0]  ext_bytes_i;
  int          miscompares, checks_done;

  hspsi_row_type rows [10] = '{
    '{1'b0, A_LOCK_CFG,  1, 32'h0},
    '{1'b0, A_DIE_VER,   1, 32'h1},
    '{1'b0, A_LAST_ADDR, 2, 32'he707},
    '{1'b0, A_LAST_D8,   1, 32'h1},
    '{1'b0, A_LAST_OPERATION_KIND,   1, 32'h35},
    '{1'b1, 16'h1000,    4, 32'hdeadbeef},
    '{1'b0, A_LAST_D32,  4, 32'hdeadbeef},
    '{1'b0, 16'h1000,    4, 32'hdeadbeef},
    '{1'b1, 16'h2000,    2, 32'ha55a},
    '{1'b0, A_LAST_D16,  2, 32'ha55a}
  };

  assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);
  assign ext_rdata_i = ext_q;
  assign ext_bytes_i = (ext_addr_o == 16'h1000) ? 3'h4 :
                       (ext_addr_o == 16'h2000) ? 3'h2 : 3'h1;
  always @(posedge clk_i) begin
    if (reset_i) begin
      ext_q <= '0;
    end else if (ext_wr_o) begin
      ext_q <= ext_wdata_o;
    end
  end

  hspsi_top i_hspsi_top (
    .clk_i, .reset_i, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_o,
    .shared_select_pin_i, .spi_cfg_wr_i, .spi_sel_o, .port_lock_o,
    .fast_capture_en_o, .ext_addr_o, .ext_wdata_o, .ext_wr_o,
    .ext_rdata_i, .ext_bytes_i
  );

  hspsi_master_model i_hspsi_master_model (
    .scl_o(scl), .sda_o(m_sda), .sda_i(sda_w)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  // Three falling edges on the select pin, each level held 10 cycles
  task automatic toggle_select();
    repeat (3) begin
      wait_clk(1);
      shared_select_pin_i = 1'b0;
      wait_clk(10);
      shared_select_pin_i = 1'b1;
      wait_clk(10);
    end
  endtask

  // Whole transfer; a read of fewer bytes than the width is an abort
  task automatic xfer(input hspsi_row_type r, output logic [31:0] v);
    logic [7:0] b;
    v = '0;
    i_hspsi_master_model.start();
    i_hspsi_master_model.send_byte({DEV_ADDR, 1'b0}, ack);
    check(ack, 1'b0);
    i_hspsi_master_model.send_byte(r.addr[15:8], ack);
    check(ack, 1'b0);
    i_hspsi_master_model.send_byte(r.addr[7:0], ack);
    check(ack, 1'b0);
    if (r.wr) begin
      for (int i = r.nb - 1; i >= 0; i--) begin
        i_hspsi_master_model.send_byte(r.data[8*i+:8], ack);
        check(ack, 1'b0);
      end
    end else begin
      i_hspsi_master_model.start();
      i_hspsi_master_model.send_byte({DEV_ADDR, 1'b1}, ack);
      check(ack, 1'b0);
      for (int i = r.nb - 1; i >= 0; i--) begin
        i_hspsi_master_model.recv_byte(i == 0, b);
        v = {v[23:0], b};
      end
    end
    i_hspsi_master_model.stop();
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    shared_select_pin_i = 1'b1;
    spi_cfg_wr_i = 1'b0;
    miscompares = 0;
    checks_done = 0;
    wait_clk(2);
    reset_i = 1'b0;
    wait_clk(5);
    check(fast_capture_en_o, 1'b0);
    foreach (rows[k]) begin
      xfer(rows[k], rd);
      if (!rows[k].wr) begin
        check(rd, rows[k].data);
      end
    end
    check(spi_sel_o, 1'b0);
    check(ext_addr_o, A_LAST_D16);
    xfer(hspsi_row_type'{1'b0, 16'h1000, 1, 32'h0}, rd);
    xfer(hspsi_row_type'{1'b0, A_LAST_OPERATION_KIND, 1, 32'h0}, rd);
    check(rd, OP_WRITE);
    xfer(hspsi_row_type'{1'b0, A_LAST_ADDR, 2, 32'h0}, rd);
    check(rd, 32'h2000);
    xfer(hspsi_row_type'{1'b1, A_LOCK_CFG, 1, 32'h3}, rd);
    wait_clk(3);
    check(port_lock_o, 1'b1);
    check(fast_capture_en_o, 1'b1);
    toggle_select();
    check(spi_sel_o, 1'b0);
    reset_i = 1'b1;
    wait_clk(2);
    reset_i = 1'b0;
    wait_clk(5);
    check(port_lock_o, 1'b0);
    check(fast_capture_en_o, 1'b0);
    toggle_select();
    check(spi_sel_o, 1'b1);
    i_hspsi_master_model.start();
    i_hspsi_master_model.send_byte({DEV_ADDR, 1'b0}, ack);
    check(ack, 1'b1);
    i_hspsi_master_model.stop();
    wait_clk(1);
    spi_cfg_wr_i = 1'b1;
    wait_clk(1);
    spi_cfg_wr_i = 1'b0;
    wait_clk(2);
    check(port_lock_o, 1'b1);
    check(fast_capture_en_o, 1'b0);
    stop_test();
  end

  // Tests need about 80,000 cycles; give up at 100,000
  initial begin
    #2500000;
    miscompares++;
    stop_test();
  end
endmodule
